// File: pgsr_pkg.sv
// constants and carriers for the peripheral gate and soft reset block
package pgsr_pkg;

  // register byte offsets
  localparam logic [11:0] PGSR_OFS_SRC0 = 12'h040;
  localparam logic [11:0] PGSR_OFS_SRC1 = 12'h044;
  localparam logic [11:0] PGSR_OFS_DSCG = 12'h128;
  localparam logic [11:0] PGSR_OFS_CFG = 12'h180;
  localparam logic [11:0] PGSR_OFS_IRQ_STAT = 12'h184;
  localparam logic [11:0] PGSR_OFS_IRQ_EN = 12'h188;
  localparam logic [11:0] PGSR_OFS_IRQ_CLR = 12'h18c;
  localparam logic [11:0] PGSR_OFS_CAP1 = 12'h190;
  localparam logic [11:0] PGSR_OFS_CAP2 = 12'h194;

  // writable positions of the soft reset and deep-sleep gating registers, and the shared reset value
  localparam logic [31:0] PGSR_SRC0_IMPL = 32'h0000_0008;
  localparam logic [31:0] PGSR_SRC1_IMPL = 32'h0107_0011;
  localparam logic [31:0] PGSR_DSCG_IMPL = 32'h0000_003f;
  localparam logic [31:0] PGSR_RESET_VAL = 32'h0000_0000;

  // field positions
  localparam int PGSR_BIT_WDOG = 3;
  localparam int PGSR_BIT_TMR0 = 16;
  localparam int PGSR_BIT_TMR1 = 17;
  localparam int PGSR_BIT_TMR2 = 18;
  localparam int PGSR_BIT_CMP0 = 24;
  localparam int PGSR_BIT_SYNC_SERIAL0_SOFT_RESET = 4;
  localparam int PGSR_BIT_ASYNC_SERIAL0_SOFT_RESET = 0;
  localparam int PGSR_BIT_ACG = 0;
  localparam int PGSR_NPORT = 6;

  // interrupt status bits
  localparam int PGSR_EV_FAULT = 0;
  localparam int PGSR_EV_MASKED = 1;
  localparam int PGSR_NEV = 2;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } pgsr_req_s;

  typedef struct packed {
    logic watchdog_soft_reset;
    logic comparator0_soft_reset;
    logic gp_counter2_soft_reset;
    logic gp_counter1_soft_reset;
    logic gp_counter0_soft_reset;
    logic sync_serial0_soft_reset;
    logic async_serial0_soft_reset;
  } pgsr_rst_s;

endpackage : pgsr_pkg

// File: pgsr_port_gate.sv
// per-port clock enable and bus fault detection
`timescale 1ns/100ps
`default_nettype none
module pgsr_port_gate
  import pgsr_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // control
  input wire logic [PGSR_NPORT-1:0] run_gate,
  input wire logic [PGSR_NPORT-1:0] deep_gate,
  input wire logic auto_clock_gating,
  input wire logic deep_sleep,
  // port access
  input wire logic [PGSR_NPORT-1:0] port_access,
  // results
  output logic [PGSR_NPORT-1:0] port_clk_en,
  output logic bus_fault
);

  logic [PGSR_NPORT-1:0] eff_gate;
  logic bus_fault_r;

  // deep-sleep set applies only with automatic gating on
  assign eff_gate = (deep_sleep && auto_clock_gating) ? deep_gate : run_gate;
  assign port_clk_en = eff_gate;

  // an access to an unclocked port faults
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      bus_fault_r <= 1'b0;
    end else begin
      bus_fault_r <= |(port_access & ~eff_gate);
    end
  end
  assign bus_fault = bus_fault_r;

endmodule : pgsr_port_gate
`default_nettype wire

// File: pgsr_top.sv
// register file, soft reset controls and port gating for the system control unit
`timescale 1ns/100ps
`default_nettype none
module pgsr_top
  import pgsr_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // system state
  input wire logic deep_sleep,
  input wire logic [PGSR_NPORT-1:0] run_gate,
  input wire logic [PGSR_NPORT-1:0] port_access,
  // gated port clocks and fault
  output logic [PGSR_NPORT-1:0] port_clk_en,
  output logic bus_fault,
  // peripheral resets
  output pgsr_rst_s unit_soft_reset,
  // interrupt
  output logic irq
);

  pgsr_req_s req;
  logic [31:0] src0_r;
  logic [31:0] src1_r;
  logic [31:0] dscg_r;
  logic [31:0] cap1_r;
  logic [31:0] cap2_r;
  logic acg_r;
  logic [PGSR_NEV-1:0] stat_r;
  logic [PGSR_NEV-1:0] irq_en_r;
  logic [PGSR_NEV-1:0] ev;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic fault;
  logic masked_wr;

  assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

  function automatic logic hit(input pgsr_req_s r, input logic [11:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction : hit

  // merge write data only where mask allows
  function automatic logic [31:0] masked(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [31:0] m);
    masked = (old & ~m) | (wd & m);
  endfunction : masked

  // capability masks, limited to implemented positions
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cap1_r <= PGSR_SRC0_IMPL;
      cap2_r <= PGSR_SRC1_IMPL;
    end else begin
      if (hit(req, PGSR_OFS_CAP1)) begin
        cap1_r <= req.wdata & PGSR_SRC0_IMPL;
      end
      if (hit(req, PGSR_OFS_CAP2)) begin
        cap2_r <= req.wdata & PGSR_SRC1_IMPL;
      end
    end
  end

  // soft reset control 0
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      src0_r <= PGSR_RESET_VAL;
    end else if (hit(req, PGSR_OFS_SRC0)) begin
      src0_r <= masked(src0_r, req.wdata, cap1_r & PGSR_SRC0_IMPL);
    end
  end

  // soft reset control 1
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      src1_r <= PGSR_RESET_VAL;
    end else if (hit(req, PGSR_OFS_SRC1)) begin
      src1_r <= masked(src1_r, req.wdata, cap2_r & PGSR_SRC1_IMPL);
    end
  end

  // deep-sleep port gating and config
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      dscg_r <= PGSR_RESET_VAL;
      acg_r <= 1'b0;
    end else begin
      if (hit(req, PGSR_OFS_DSCG)) begin
        dscg_r <= req.wdata & PGSR_DSCG_IMPL;
      end
      if (hit(req, PGSR_OFS_CFG)) begin
        acg_r <= req.wdata[PGSR_BIT_ACG];
      end
    end
  end

  // resets follow the register bits directly
  always_comb begin
    unit_soft_reset.watchdog_soft_reset = src0_r[PGSR_BIT_WDOG];
    unit_soft_reset.gp_counter2_soft_reset = src1_r[PGSR_BIT_TMR2];
    unit_soft_reset.gp_counter1_soft_reset = src1_r[PGSR_BIT_TMR1];
    unit_soft_reset.gp_counter0_soft_reset = src1_r[PGSR_BIT_TMR0];
    unit_soft_reset.comparator0_soft_reset = src1_r[PGSR_BIT_CMP0];
    unit_soft_reset.sync_serial0_soft_reset = src1_r[PGSR_BIT_SYNC_SERIAL0_SOFT_RESET];
    unit_soft_reset.async_serial0_soft_reset = src1_r[PGSR_BIT_ASYNC_SERIAL0_SOFT_RESET];
  end

  pgsr_port_gate u_gate (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .run_gate(run_gate),
    .deep_gate(dscg_r[PGSR_NPORT-1:0]),
    .auto_clock_gating(acg_r),
    .deep_sleep(deep_sleep),
    .port_access(port_access),
    .port_clk_en(port_clk_en),
    .bus_fault(fault)
  );
  assign bus_fault = fault;

  // a write that tried to touch a bit the capability mask blocks
  assign masked_wr = (hit(req, PGSR_OFS_SRC0) && |(req.wdata & ~cap1_r & PGSR_SRC0_IMPL))
                  || (hit(req, PGSR_OFS_SRC1) && |(req.wdata & ~cap2_r & PGSR_SRC1_IMPL));

  always_comb begin
    ev = '0;
    ev[PGSR_EV_FAULT] = fault;
    ev[PGSR_EV_MASKED] = masked_wr;
  end

  // sticky status; a new event beats a same-cycle clear
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      stat_r <= '0;
    end else if (hit(req, PGSR_OFS_IRQ_CLR)) begin
      stat_r <= (stat_r & ~req.wdata[PGSR_NEV-1:0]) | ev;
    end else begin
      stat_r <= stat_r | ev;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      irq_en_r <= '0;
    end else if (hit(req, PGSR_OFS_IRQ_EN)) begin
      irq_en_r <= req.wdata[PGSR_NEV-1:0];
    end
  end

  assign irq = |(stat_r & irq_en_r);

  // read mux; unmapped and write-only addresses read zero
  always_comb begin
    rdata_nxt = '0;
    case (req.addr)
      PGSR_OFS_SRC0: rdata_nxt = src0_r & PGSR_SRC0_IMPL;
      PGSR_OFS_SRC1: rdata_nxt = src1_r & PGSR_SRC1_IMPL;
      PGSR_OFS_DSCG: rdata_nxt = dscg_r;
      PGSR_OFS_CFG: rdata_nxt = {31'h0000_0000, acg_r};
      PGSR_OFS_IRQ_STAT: rdata_nxt = {30'h0000_0000, stat_r};
      PGSR_OFS_IRQ_EN: rdata_nxt = {30'h0000_0000, irq_en_r};
      PGSR_OFS_CAP1: rdata_nxt = cap1_r;
      PGSR_OFS_CAP2: rdata_nxt = cap2_r;
      default: rdata_nxt = '0;
    endcase
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rdata_r <= '0;
    end else if (req.rd) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= '0;
    end
  end
  assign reg_rdata = rdata_r;

endmodule : pgsr_top
`default_nettype wire

// File: pgsr_top_chk.sv
// bound checker for the gate and soft reset block
`timescale 1ns/100ps
`default_nettype none
module pgsr_top_chk
  import pgsr_pkg::*;
(
  // every top port, watched only
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic deep_sleep,
  input wire logic [PGSR_NPORT-1:0] run_gate,
  input wire logic [PGSR_NPORT-1:0] port_access,
  input wire logic [PGSR_NPORT-1:0] port_clk_en,
  input wire logic bus_fault,
  input wire pgsr_rst_s unit_soft_reset,
  input wire logic irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // shadow of capability mask 1, rebuilt from bus writes
  logic [31:0] cap1_m;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cap1_m <= PGSR_SRC0_IMPL;
    end else if (reg_wr && reg_addr == PGSR_OFS_CAP1) begin
      cap1_m <= reg_wdata & PGSR_SRC0_IMPL;
    end
  end
  a_wdog_write: assert property (reg_wr && reg_addr == PGSR_OFS_SRC0 |=>
    unit_soft_reset.watchdog_soft_reset == ($past(cap1_m[3]) ? $past(reg_wdata[3])
    : $past(unit_soft_reset.watchdog_soft_reset))) else $error("watchdog reset bit wrong");
  a_cmp_write: assert property (reg_wr && reg_addr == PGSR_OFS_SRC1 |=>
    unit_soft_reset.comparator0_soft_reset == $past(reg_wdata[24])) else $error("comparator reset bit wrong");
  a_tmr_write: assert property (reg_wr && reg_addr == PGSR_OFS_SRC1 |=>
    unit_soft_reset[4:2] == $past(reg_wdata[18:16])) else $error("timer reset bits wrong");
  a_ser_write: assert property (reg_wr && reg_addr == PGSR_OFS_SRC1 |=>
    unit_soft_reset[1:0] == {$past(reg_wdata[4]), $past(reg_wdata[0])}) else $error("serial reset bits wrong");
  a_rst_steady: assert property (!(reg_wr && (reg_addr == PGSR_OFS_SRC0 || reg_addr == PGSR_OFS_SRC1))
    |=> $stable(unit_soft_reset)) else $error("reset bits moved without write");
  a_rsvd_zero: assert property (reg_rd && reg_addr == PGSR_OFS_SRC1 |=>
    (reg_rdata & ~PGSR_SRC1_IMPL) == 32'h0) else $error("reserved bits not zero");
  a_fault_set: assert property (|(port_access & ~port_clk_en) |=> bus_fault)
    else $error("missing bus fault");
  a_fault_none: assert property (!(|(port_access & ~port_clk_en)) |=> !bus_fault)
    else $error("spurious bus fault");
  a_run_gate: assert property (!deep_sleep |-> port_clk_en == run_gate)
    else $error("run gate not followed");
endmodule : pgsr_top_chk
bind pgsr_top pgsr_top_chk i_pgsr_top_chk (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .deep_sleep, .run_gate, .port_access, .port_clk_en, .bus_fault, .unit_soft_reset, .irq);
`default_nettype wire

// File: pgsr_top_tb.sv
// self-checking bench for the gate and soft reset block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_total++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module pgsr_top_tb import pgsr_pkg::*;;
  logic clk_sys = 1'h0, rstn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, deep_sleep = 1'h0;
  logic [11:0] reg_addr = 12'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [5:0] run_gate = 6'h0, port_access = 6'h0, port_clk_en;
  logic bus_fault, irq;
  pgsr_rst_s unit_soft_reset;
  int err_total = 0, check_count = 0;
  int bit_pos[6] = '{24, 18, 17, 16, 4, 0};
  pgsr_top i_pgsr_top (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .deep_sleep,
    .run_gate, .port_access, .port_clk_en, .bus_fault, .unit_soft_reset, .irq);
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
    #1;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1 `CHK(reg_rdata, e)
  endtask : rd
  // one access cycle, fault judged the cycle after
  task automatic acc(input logic [5:0] m, input logic f);
    @(posedge clk_sys);
    port_access <= m;
    @(posedge clk_sys);
    port_access <= 6'h0;
    #1 `CHK(bus_fault, f)
  endtask : acc
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  task automatic t_src;
    rd(PGSR_OFS_SRC0, 32'h0);
    rd(PGSR_OFS_SRC1, 32'h0);
    rd(12'h3fc, 32'h0);
    wr(PGSR_OFS_SRC0, 32'hffff_ffff);
    `CHK(unit_soft_reset, 7'h40)
    rd(PGSR_OFS_SRC0, 32'h0000_0008);
    wr(PGSR_OFS_SRC1, 32'hffff_ffff);
    `CHK(unit_soft_reset, 7'h7f)
    rd(PGSR_OFS_SRC1, 32'h0107_0011);
    wr(PGSR_OFS_SRC0, 32'h0);
    `CHK(unit_soft_reset, 7'h3f)
    for (int i = 0; i < 6; i++) begin
      wr(PGSR_OFS_SRC1, 32'h1 << bit_pos[i]);
      `CHK(unit_soft_reset, 7'h20 >> i)
    end
    wr(PGSR_OFS_SRC1, 32'hfef8_ffee);
    rd(PGSR_OFS_SRC1, 32'h0);
    $display("soft reset test done");
  endtask : t_src
  task automatic t_irq;
    wr(PGSR_OFS_IRQ_CLR, 32'h3);
    wr(PGSR_OFS_IRQ_EN, 32'h2);
    // mask 1 cleared, so the watchdog write is refused and flagged
    wr(PGSR_OFS_CAP1, 32'h0);
    wr(PGSR_OFS_SRC0, 32'h8);
    `CHK(unit_soft_reset, 7'h00)
    rd(PGSR_OFS_IRQ_STAT, 32'h2);
    `CHK(irq, 1'h1)
    wr(PGSR_OFS_IRQ_EN, 32'h0);
    `CHK(irq, 1'h0)
    wr(PGSR_OFS_IRQ_EN, 32'h2);
    wr(PGSR_OFS_IRQ_CLR, 32'h2);
    rd(PGSR_OFS_IRQ_STAT, 32'h0);
    `CHK(irq, 1'h0)
    wr(PGSR_OFS_CAP1, 32'h8);
    wr(PGSR_OFS_SRC0, 32'h8);
    `CHK(unit_soft_reset, 7'h40)
    wr(PGSR_OFS_SRC0, 32'h0);
    $display("interrupt test done");
  endtask : t_irq
  task automatic t_gate;
    @(posedge clk_sys);
    run_gate <= 6'h2a;
    acc(6'h01, 1'h1);
    acc(6'h02, 1'h0);
    wr(PGSR_OFS_DSCG, 32'hffff_ff15);
    rd(PGSR_OFS_DSCG, 32'h15);
    @(posedge clk_sys);
    deep_sleep <= 1'h1;
    acc(6'h20, 1'h0);
    `CHK(port_clk_en, 6'h2a)
    wr(PGSR_OFS_CFG, 32'h1);
    `CHK(port_clk_en, 6'h15)
    acc(6'h02, 1'h1);
    $display("port gate test done");
  endtask : t_gate
  initial begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1'h1;
    t_src;
    t_irq;
    t_gate;
    give_verdict;
  end
  // whole run is under a hundred cycles
  initial begin
    #20000;
    err_total++;
    give_verdict;
  end
endmodule : pgsr_top_tb
`default_nettype wire
